//--- hw/atcr_pkg.sv
// Constants and types shared by the task-file command control block.
// Notes on behaviour
// R1: Start a command only after a command write, with busy clear and ready set.
// R2: The byte written to the command register selects the disk operation.
// R3: An unknown command code ends at once with an aborted-command error.
// R4: Every command register write drops the pending interrupt request.
// R5: Codes 40h and 41h are verify-read, 42h its extended form.
// R6: Code 27h is extended read-native-maximum, F8h its short form.
// R7: The host loads every used parameter register before writing the command.
// R8: Parameters a command does not use are ignored and passed on as zero.
// R9: Drive select is bit 4 of the drive/head register.
// R10: Head select is bits 3 to 0 of the drive/head register.
// R11: The cylinder is built from the cylinder low and high registers.
// R12: Features come from the register that also serves as write precompensation.
// R13: Alternate status reads return exactly the primary status bits.
// R14: Alternate status reads never acknowledge or clear a pending interrupt.
// R15: Any command register write clears the high-order-byte select bit.
// R16: Device control bits 6 to 4 and 0 are unused; host writes bit 3 as one.
// R17: While soft reset is one, hold busy and return internal registers to reset.
// R18: Soft reset acts on both chained drives, whatever drive select holds.
// R19: With interrupts enabled and this drive selected, the interrupt line is driven.
// R20: With interrupts disabled the interrupt line stays undriven.
// R21: Busy sets on a command write and holds until completion or data request.
// R22: A primary status read while an interrupt is pending clears it.
// R23: A command write while busy or not ready starts nothing.
package atcr_pkg;
  localparam logic [2:0] ADDR_FEAT = 3'h1;
  localparam logic [2:0] ADDR_LAST_PARAM = 3'h5;
  localparam logic [2:0] ADDR_DRV_HEAD = 3'h6;
  localparam logic [2:0] ADDR_CMD_STAT = 3'h7;
  localparam logic [2:0] ADDR_ALT_DEVCTL = 3'h6;
  localparam int DC_HOB = 7;
  localparam int DC_SOFT_RESET_BIT = 2;
  localparam int DC_IDIS = 1;
  localparam int DH_DRV = 4;
  localparam int DH_HEAD_MSB = 3;
  localparam int ERR_ABORT_BIT = 2;
  localparam int USE_SC = 5;
  localparam int USE_SN = 4;
  localparam int USE_CY = 3;
  localparam int USE_DRV_BIT = 2;
  localparam int USE_HD = 1;
  localparam int USE_FT = 0;
  localparam logic [5:0] USE_DRV = 6'h04;
  localparam logic [5:0] USE_XFER = 6'h3e;
  localparam logic [5:0] USE_SEEK = 6'h0e;
  localparam logic [5:0] USE_INIT = 6'h26;
  localparam logic [5:0] USE_LOAD = 6'h35;
  localparam logic [5:0] USE_SMART = 6'h0d;
  localparam logic [5:0] USE_DRVFT = 6'h05;
  localparam logic [5:0] USE_SCDRV = 6'h24;
  localparam logic [7:0] CMD_VERIFY = 8'h40;
  localparam logic [7:0] CMD_VERIFY_ALT = 8'h41;
  localparam logic [7:0] CMD_VERIFY_EXT = 8'h42;
  localparam logic [7:0] CMD_NATMAX_EXT = 8'h27;
  localparam logic [7:0] CMD_NATMAX = 8'hf8;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int PIN_W = 15;
  localparam logic [14:0] PIN_IDLE = 15'h7fff;
  typedef enum logic [2:0] {
    KIND_OTHER, KIND_VERIFY, KIND_VERIFY_EXT, KIND_NATMAX, KIND_NATMAX_EXT
  } atcr_kind_e;
endpackage

//--- hw/atcr_dec_if.sv
// Carrier between the task-file control and the command code decoder.
`timescale 1ns/100ps
interface atcr_dec_if;
  logic [7:0] code;
  logic known;
  logic [5:0] useMask;
  atcr_pkg::atcr_kind_e kind;
  modport dec (input code, output known, useMask, kind);
  modport ctl (output code, input known, useMask, kind);
endinterface

//--- hw/atcr_pin_sync.sv
// Three-stage synchroniser with agreement filter for the task-file pins.
`timescale 1ns/100ps
module atcr_pin_sync #(
  parameter int W = 15,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic clk_sys,
  input wire logic soft_reset_bit,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinStable
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] stable_q;

  always_ff @(posedge clk_sys) begin
    if (soft_reset_bit) begin
      s1_q <= IDLE;
      s2_q <= IDLE;
      s3_q <= IDLE;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit moves only when the last two stages agree, so one noisy sample is dropped.
  always_ff @(posedge clk_sys) begin
    if (soft_reset_bit) begin
      stable_q <= IDLE;
    end else begin
      stable_q <= (s2_q & s3_q) | (stable_q & (s2_q ^ s3_q));
    end
  end

  assign pinStable = stable_q;
endmodule

//--- hw/atcr_cmd_decode.sv
// Command code table: known codes, parameter use and special kinds.
`timescale 1ns/100ps
module atcr_cmd_decode (
  atcr_dec_if.dec dif
);
  function automatic logic [6:0] lookUp(input logic [7:0] c);
    logic [6:0] r;
    r = 7'h00;
    casez (c)
      8'h00, 8'h1?, 8'h27, 8'h90, 8'he4, 8'he7, 8'he8, 8'hea, 8'hec,
      8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf8: begin
        r = {1'b1, atcr_pkg::USE_DRV};
      end
      8'h20, 8'h21, 8'h24, 8'h25, 8'h29, 8'h30, 8'h31, 8'h34, 8'h35,
      8'h37, 8'h39, 8'h3c, 8'h40, 8'h41, 8'h42, 8'hc4, 8'hc5, 8'hc8,
      8'hc9, 8'hca, 8'hcb, 8'hf9: begin
        r = {1'b1, atcr_pkg::USE_XFER};
      end
      8'h50, 8'h7?: begin
        r = {1'b1, atcr_pkg::USE_SEEK};
      end
      8'h91: begin
        r = {1'b1, atcr_pkg::USE_INIT};
      end
      8'h92: begin
        r = {1'b1, atcr_pkg::USE_LOAD};
      end
      8'hb0: begin
        r = {1'b1, atcr_pkg::USE_SMART};
      end
      8'hb1, 8'hef, 8'hfc: begin
        r = {1'b1, atcr_pkg::USE_DRVFT};
      end
      8'hc6, 8'he0, 8'he1, 8'he2, 8'he3, 8'he5, 8'he6, 8'h94, 8'h95,
      8'h96, 8'h97, 8'h98, 8'h99: begin
        r = {1'b1, atcr_pkg::USE_SCDRV};
      end
      default: begin
        r = 7'h00;
      end
    endcase
    return r;
  endfunction

  logic [6:0] entry;

  always_comb begin
    entry = lookUp(dif.code); // R2
    dif.known = entry[6]; // R3
    dif.useMask = entry[5:0];
    case (dif.code)
      atcr_pkg::CMD_VERIFY, atcr_pkg::CMD_VERIFY_ALT: dif.kind = atcr_pkg::KIND_VERIFY; // R5
      atcr_pkg::CMD_VERIFY_EXT: dif.kind = atcr_pkg::KIND_VERIFY_EXT; // R5
      atcr_pkg::CMD_NATMAX: dif.kind = atcr_pkg::KIND_NATMAX; // R6
      atcr_pkg::CMD_NATMAX_EXT: dif.kind = atcr_pkg::KIND_NATMAX_EXT; // R6
      default: dif.kind = atcr_pkg::KIND_OTHER;
    endcase
  end
endmodule

//--- hw/atcr_task_file.sv
// Task-file command, alternate status and device control logic of the drive.
`timescale 1ns/100ps
module atcr_task_file (
  input wire logic clk_sys,
  input wire logic soft_reset_bit,
  input wire logic chipSelect0N,
  input wire logic chipSelect1N,
  input wire logic [2:0] regAddrLines,
  input wire logic [7:0] dataIn,
  input wire logic iorN,
  input wire logic iowN,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic intrqOut,
  output logic intrqOe,
  input wire logic driveId,
  input wire logic driveReadyFlag,
  input wire logic deviceFault,
  input wire logic seekComplete,
  input wire logic dataRequest,
  input wire logic cmdDone,
  input wire logic irqEvent,
  output logic cmdStart,
  output logic [7:0] cmdCode,
  output atcr_pkg::atcr_kind_e cmdKind,
  output logic [15:0] sectorCountParam,
  output logic [15:0] sectorNumberParam,
  output logic [31:0] cylinderParam,
  output logic driveSelectParam,
  output logic [3:0] headSelectParam,
  output logic [15:0] featuresParam,
  output logic busyFlag,
  output logic softResetOut,
  output logic highOrderByteSelect,
  output logic abortErr
);
  logic [14:0] pinStable;
  logic cs0N;
  logic cs1N;
  logic [2:0] addrS;
  logic [7:0] dataS;
  logic iorS;
  logic iowS;
  logic iowPrev_q;
  logic iorPrev_q;
  logic wrEnd;
  logic rdStart;
  logic wrCmd;
  logic wrDevCtl;
  logic rdStatus;
  logic rdAlt;
  logic accept;
  logic startNow;
  logic abortNow;
  logic internalRst;
  logic rstHeld_q;
  logic busyFlag_q;
  logic softResetBit_q;
  logic interruptDisableBit_q;
  logic hob_q;
  logic errBit_q;
  logic intPending_q;
  logic [7:0] tfCur_q [1:5];
  logic [7:0] tfPrev_q [1:5];
  logic [7:0] drvHead_q;
  logic [7:0] statusByte;
  logic [7:0] readMux;
  logic readSel;
  logic [7:0] dataOut_q;
  logic dataOe_q;
  logic intrqOut_q;
  logic intrqOe_q;
  logic cmdStart_q;
  logic [7:0] cmdCode_q;
  atcr_pkg::atcr_kind_e cmdKind_q;
  logic [15:0] sectorCount_q;
  logic [15:0] sectorNumber_q;
  logic [31:0] cylinder_q;
  logic driveSel_q;
  logic [3:0] headSel_q;
  logic [15:0] features_q;

  atcr_dec_if dIf ();

  // Every host pin is asynchronous to the drive clock.
  atcr_pin_sync #(
    .W(atcr_pkg::PIN_W),
    .IDLE(atcr_pkg::PIN_IDLE)
  ) uSync (
    .clk_sys(clk_sys),
    .soft_reset_bit(soft_reset_bit),
    .pinIn({chipSelect0N, chipSelect1N, regAddrLines, dataIn, iorN, iowN}),
    .pinStable(pinStable)
  );

  atcr_cmd_decode uDecode (
    .dif(dIf)
  );

  assign cs0N = pinStable[14];
  assign cs1N = pinStable[13];
  assign addrS = pinStable[12:10];
  assign dataS = pinStable[9:2];
  assign iorS = pinStable[1];
  assign iowS = pinStable[0];
  assign dIf.code = dataS;

  function automatic logic hits(input logic b0N, input logic b1N, input logic cs1,
                                input logic [2:0] a, input logic [2:0] want);
    return (cs1 ? (b0N && !b1N) : (!b0N && b1N)) && (a == want);
  endfunction

  // Writes take effect at the end of the strobe, when the host data is settled.
  always_ff @(posedge clk_sys) begin
    if (soft_reset_bit) begin
      iowPrev_q <= 1'b1;
      iorPrev_q <= 1'b1;
    end else begin
      iowPrev_q <= iowS;
      iorPrev_q <= iorS;
    end
  end

  assign wrEnd = !iowPrev_q && iowS;
  assign rdStart = iorPrev_q && !iorS;
  assign wrCmd = wrEnd && hits(cs0N, cs1N, 1'b0, addrS, atcr_pkg::ADDR_CMD_STAT);
  assign wrDevCtl = wrEnd && hits(cs0N, cs1N, 1'b1, addrS, atcr_pkg::ADDR_ALT_DEVCTL);
  assign rdStatus = rdStart && hits(cs0N, cs1N, 1'b0, addrS, atcr_pkg::ADDR_CMD_STAT);
  assign rdAlt = rdStart && hits(cs0N, cs1N, 1'b1, addrS, atcr_pkg::ADDR_ALT_DEVCTL);

  assign internalRst = soft_reset_bit || softResetBit_q;
  assign accept = wrCmd && !busyFlag_q && driveReadyFlag && !softResetBit_q; // R1 R23
  assign startNow = accept && dIf.known;
  assign abortNow = accept && !dIf.known; // R3

  // Device control is taken by both chained drives regardless of drive select.
  always_ff @(posedge clk_sys) begin
    if (soft_reset_bit) begin
      softResetBit_q <= 1'b0;
      interruptDisableBit_q <= 1'b0;
    end else if (wrDevCtl) begin // R18
      softResetBit_q <= dataS[atcr_pkg::DC_SOFT_RESET_BIT]; // R17
      interruptDisableBit_q <= dataS[atcr_pkg::DC_IDIS]; // R20
    end
  end

  always_ff @(posedge clk_sys) begin
    if (soft_reset_bit) begin
      hob_q <= 1'b0;
    end else if (wrCmd) begin
      hob_q <= 1'b0; // R15
    end else if (wrDevCtl) begin
      hob_q <= dataS[atcr_pkg::DC_HOB];
    end
  end

  // Parameter writes are dropped while busy so a running command keeps its inputs.
  always_ff @(posedge clk_sys) begin
    if (internalRst) begin // R17
      for (int i = 1; i <= 5; i++) begin
        tfCur_q[i] <= atcr_pkg::REG_RST;
        tfPrev_q[i] <= atcr_pkg::REG_RST;
      end
    end else if (wrEnd && !busyFlag_q && !cs0N && cs1N && addrS >= atcr_pkg::ADDR_FEAT
                 && addrS <= atcr_pkg::ADDR_LAST_PARAM) begin
      tfPrev_q[addrS] <= tfCur_q[addrS];
      tfCur_q[addrS] <= dataS;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (internalRst) begin
      drvHead_q <= atcr_pkg::REG_RST;
    end else if (wrEnd && !busyFlag_q
                 && hits(cs0N, cs1N, 1'b0, addrS, atcr_pkg::ADDR_DRV_HEAD)) begin
      drvHead_q <= dataS;
    end
  end

  // Busy is released one cycle after every reset source has gone.
  always_ff @(posedge clk_sys) begin
    if (soft_reset_bit) begin
      rstHeld_q <= 1'b1;
    end else begin
      rstHeld_q <= softResetBit_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (internalRst) begin
      busyFlag_q <= 1'b1; // R17
    end else if (startNow) begin
      busyFlag_q <= 1'b1; // R21
    end else if (cmdDone || dataRequest || rstHeld_q) begin
      busyFlag_q <= 1'b0; // R21
    end
  end

  always_ff @(posedge clk_sys) begin
    if (internalRst) begin
      errBit_q <= 1'b0;
    end else if (abortNow) begin
      errBit_q <= 1'b1; // R3
    end else if (startNow) begin
      errBit_q <= 1'b0;
    end
  end

  // A new event in the same cycle as an acknowledge keeps the request pending.
  always_ff @(posedge clk_sys) begin
    if (internalRst) begin
      intPending_q <= 1'b0;
    end else if (irqEvent || abortNow) begin
      intPending_q <= 1'b1;
    end else if (wrCmd || rdStatus) begin
      intPending_q <= 1'b0; // R4 R22 R14
    end
  end

  always_ff @(posedge clk_sys) begin
    if (soft_reset_bit) begin
      intrqOut_q <= 1'b0;
      intrqOe_q <= 1'b0;
    end else begin
      intrqOut_q <= intPending_q;
      intrqOe_q <= !interruptDisableBit_q && (drvHead_q[atcr_pkg::DH_DRV] == driveId); // R19 R20
    end
  end

  assign statusByte = {busyFlag_q, driveReadyFlag, deviceFault, seekComplete,
                       dataRequest, 2'b00, errBit_q};

  always_comb begin
    readSel = 1'b0;
    readMux = 8'h00;
    if (!iorS && cs0N && !cs1N && addrS == atcr_pkg::ADDR_ALT_DEVCTL) begin
      readSel = 1'b1;
      readMux = statusByte; // R13
    end else if (!iorS && !cs0N && cs1N) begin
      readSel = 1'b1;
      if (addrS == atcr_pkg::ADDR_CMD_STAT) begin
        readMux = statusByte;
      end else if (addrS == atcr_pkg::ADDR_DRV_HEAD) begin
        readMux = drvHead_q;
      end else if (addrS == atcr_pkg::ADDR_FEAT) begin
        readMux = 8'h00;
        readMux[atcr_pkg::ERR_ABORT_BIT] = errBit_q;
      end else if (addrS != 3'h0) begin
        readMux = hob_q ? tfPrev_q[addrS] : tfCur_q[addrS];
      end else begin
        readSel = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (soft_reset_bit) begin
      dataOut_q <= 8'h00;
      dataOe_q <= 1'b0;
    end else begin
      dataOut_q <= readMux;
      dataOe_q <= readSel;
    end
  end

  // Unused parameters are zeroed so later logic cannot depend on stale host data.
  always_ff @(posedge clk_sys) begin
    if (internalRst) begin
      cmdStart_q <= 1'b0;
      cmdCode_q <= 8'h00;
      cmdKind_q <= atcr_pkg::KIND_OTHER;
      sectorCount_q <= 16'h0000;
      sectorNumber_q <= 16'h0000;
      cylinder_q <= 32'h0000_0000;
      driveSel_q <= 1'b0;
      headSel_q <= 4'h0;
      features_q <= 16'h0000;
    end else begin
      cmdStart_q <= startNow; // R1
      if (startNow) begin
        cmdCode_q <= dataS; // R2
        cmdKind_q <= dIf.kind; // R5 R6
        sectorCount_q <= dIf.useMask[atcr_pkg::USE_SC] ? {tfPrev_q[2], tfCur_q[2]} : 16'h0000; // R8
        sectorNumber_q <= dIf.useMask[atcr_pkg::USE_SN] ? {tfPrev_q[3], tfCur_q[3]} : 16'h0000; // R8
        cylinder_q <= dIf.useMask[atcr_pkg::USE_CY] ?
                      {tfPrev_q[5], tfPrev_q[4], tfCur_q[5], tfCur_q[4]} : 32'h0000_0000; // R11
        driveSel_q <= dIf.useMask[atcr_pkg::USE_DRV_BIT] && drvHead_q[atcr_pkg::DH_DRV]; // R9
        headSel_q <= dIf.useMask[atcr_pkg::USE_HD] ?
                     drvHead_q[atcr_pkg::DH_HEAD_MSB:0] : 4'h0; // R10
        features_q <= dIf.useMask[atcr_pkg::USE_FT] ? {tfPrev_q[1], tfCur_q[1]} : 16'h0000; // R12
      end
    end
  end

  assign dataOut = dataOut_q;
  assign dataOe = dataOe_q;
  assign intrqOut = intrqOut_q;
  assign intrqOe = intrqOe_q;
  assign cmdStart = cmdStart_q;
  assign cmdCode = cmdCode_q;
  assign cmdKind = cmdKind_q;
  assign sectorCountParam = sectorCount_q;
  assign sectorNumberParam = sectorNumber_q;
  assign cylinderParam = cylinder_q;
  assign driveSelectParam = driveSel_q;
  assign headSelectParam = headSel_q;
  assign featuresParam = features_q;
  assign busyFlag = busyFlag_q;
  assign softResetOut = softResetBit_q;
  assign highOrderByteSelect = hob_q;
  assign abortErr = errBit_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (soft_reset_bit);

  a_start_needs_ready: assert property (wrCmd && (busyFlag_q || !driveReadyFlag) |=> !cmdStart_q)
    else $error("command started while busy or not ready"); // R23
  a_start_gate: assert property (cmdStart_q |-> $past(wrCmd) && !$past(busyFlag_q))
    else $error("command start without a clean command write"); // R1
  a_abort_unknown: assert property (abortNow |=> errBit_q && !cmdStart_q && intPending_q)
    else $error("unknown code did not abort"); // R3
  a_cmd_drops_irq: assert property (wrCmd && !irqEvent && !abortNow |=> !intPending_q)
    else $error("command write left interrupt pending"); // R4
  a_verify_kind: assert property (cmdStart_q && cmdCode_q == atcr_pkg::CMD_VERIFY_EXT
                                  |-> cmdKind_q == atcr_pkg::KIND_VERIFY_EXT)
    else $error("extended verify code not decoded"); // R5
  a_natmax_unused: assert property (cmdStart_q && cmdKind_q == atcr_pkg::KIND_NATMAX
                                    |-> sectorCount_q == 16'h0000 && cylinder_q == 32'h0)
    else $error("unused parameters passed on"); // R6
  a_alt_mirror: assert property (rdAlt ##1 !iorS |-> dataOe_q && dataOut_q == $past(statusByte))
    else $error("alternate status differs from status"); // R13
  a_alt_keeps_irq: assert property (rdAlt && intPending_q && !softResetBit_q |=> intPending_q)
    else $error("alternate status read cleared interrupt"); // R14
  a_hob_cleared: assert property (hob_q && wrCmd |=> !hob_q)
    else $error("high order byte select survived a command write"); // R15
  a_soft_reset_busy: assert property (softResetBit_q |=> busyFlag_q && !intPending_q)
    else $error("soft reset did not hold busy"); // R17
  a_irq_disabled: assert property (interruptDisableBit_q |=> !intrqOe_q)
    else $error("interrupt line driven while disabled"); // R20
  a_busy_on_start: assert property (startNow |=> busyFlag_q && cmdStart_q)
    else $error("busy not set at command start"); // R21
  a_status_ack: assert property (rdStatus && !irqEvent && !abortNow |=> !intPending_q)
    else $error("status read did not acknowledge"); // R22

  c_cmd_started: cover property (cmdStart_q);
  c_cmd_aborted: cover property (abortNow);
  c_status_ack: cover property (rdStatus && intPending_q);
  c_soft_reset: cover property (softResetBit_q ##1 !softResetBit_q);
endmodule

//--- testbench/atcr_host_model.sv
// Host-side driver of the task-file pins, with strobe spacing kept well above the filter.
`timescale 1ns/100ps
module atcr_host_model (
  input wire logic clk_sys,
  output logic chipSelect0N,
  output logic chipSelect1N,
  output logic [2:0] regAddrLines,
  output logic [7:0] dataIn,
  output logic iorN,
  output logic iowN,
  input wire logic [7:0] dataOut,
  input wire logic dataOe
);
  initial begin
    chipSelect0N = 1'b1;
    chipSelect1N = 1'b1;
    regAddrLines = 3'h0;
    dataIn = 8'h00;
    iorN = 1'b1;
    iowN = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic sel(input logic alt, input logic [2:0] a, input logic [7:0] d);
    chipSelect0N = alt;
    chipSelect1N = !alt;
    regAddrLines = a;
    dataIn = d;
  endtask

  // Address and data lines show the inverse of their last value and both chip selects go high, so that no stale byte looks valid.
  task automatic park();
    chipSelect0N = 1'b1;
    chipSelect1N = 1'b1;
    regAddrLines = ~regAddrLines;
    dataIn = ~dataIn;
  endtask

  task automatic wr(input logic alt, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (alt && a == atcr_pkg::ADDR_ALT_DEVCTL) v[3] = 1'b1;
    sel(alt, a, v);
    hold(7);
    iowN = 1'b0;
    hold(6);
    iowN = 1'b1;
    hold(9);
    park();
    hold(2);
  endtask

  task automatic rd(input logic alt, input logic [2:0] a, output logic [7:0] d);
    sel(alt, a, ~dataIn);
    hold(7);
    iorN = 1'b0;
    hold(8);
    d = (dataOe === 1'b1) ? dataOut : 8'hxx;
    iorN = 1'b1;
    hold(8);
    park();
    hold(2);
  endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench of the task-file command, alternate status and device control logic.
`timescale 1ns/100ps
module tb_top;
  typedef struct {
    logic [7:0] code;
    atcr_pkg::atcr_kind_e kind;
    logic [15:0] sc;
    logic [7:0] sn;
    logic drv;
    logic [15:0] cy;
    logic [3:0] hd;
    logic [7:0] ft;
  } atcr_exp_s;

  logic clk_sys, soft_reset_bit, chipSelect0N, chipSelect1N, iorN, iowN, dataOe, intrqOut, intrqOe;
  logic [2:0] regAddrLines;
  logic [7:0] dataIn, dataOut, cmdCode, d;
  logic driveId, driveReadyFlag, deviceFault, seekComplete, dataRequest, cmdDone, irqEvent;
  logic cmdStart, driveSelectParam, busyFlag, softResetOut, highOrderByteSelect, abortErr;
  atcr_pkg::atcr_kind_e cmdKind;
  logic [15:0] sectorCountParam, sectorNumberParam, featuresParam;
  logic [31:0] cylinderParam;
  logic [3:0] headSelectParam;
  logic [31:0] seed = 32'h0000c59c;
  // The sector count register keeps its previous byte as the high half of the parameter.
  logic [7:0] lastSc = 8'h00;
  logic [7:0] codes [6] = '{8'h40, 8'h41, 8'h42, 8'h27, 8'hf8, 8'hef};
  int n_mismatch = 0;
  int cmp_count = 0;
  atcr_exp_s expQ[$];
  atcr_exp_s got;

  atcr_task_file i_atcr_task_file (.clk_sys(clk_sys), .soft_reset_bit(soft_reset_bit),
    .chipSelect0N(chipSelect0N), .chipSelect1N(chipSelect1N), .regAddrLines(regAddrLines),
    .dataIn(dataIn), .iorN(iorN), .iowN(iowN), .dataOut(dataOut), .dataOe(dataOe),
    .intrqOut(intrqOut), .intrqOe(intrqOe), .driveId(driveId),
    .driveReadyFlag(driveReadyFlag), .deviceFault(deviceFault), .seekComplete(seekComplete),
    .dataRequest(dataRequest), .cmdDone(cmdDone), .irqEvent(irqEvent), .cmdStart(cmdStart),
    .cmdCode(cmdCode), .cmdKind(cmdKind), .sectorCountParam(sectorCountParam),
    .sectorNumberParam(sectorNumberParam), .cylinderParam(cylinderParam),
    .driveSelectParam(driveSelectParam), .headSelectParam(headSelectParam),
    .featuresParam(featuresParam), .busyFlag(busyFlag), .softResetOut(softResetOut),
    .highOrderByteSelect(highOrderByteSelect), .abortErr(abortErr));

  atcr_host_model i_atcr_host_model (.clk_sys(clk_sys), .chipSelect0N(chipSelect0N),
    .chipSelect1N(chipSelect1N), .regAddrLines(regAddrLines), .dataIn(dataIn),
    .iorN(iorN), .iowN(iowN), .dataOut(dataOut), .dataOe(dataOe));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic atcr_pkg::atcr_kind_e kindOf(input logic [7:0] c);
    case (c)
      8'h40, 8'h41: return atcr_pkg::KIND_VERIFY;
      8'h42: return atcr_pkg::KIND_VERIFY_EXT;
      8'hf8: return atcr_pkg::KIND_NATMAX;
      8'h27: return atcr_pkg::KIND_NATMAX_EXT;
      default: return atcr_pkg::KIND_OTHER;
    endcase
  endfunction

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic hw(input logic alt, input logic [2:0] a, input logic [7:0] v);
    i_atcr_host_model.wr(alt, a, v);
  endtask

  task automatic pulse(input logic [1:0] kind);
    @(negedge clk_sys);
    irqEvent = (kind == 2'd1);
    dataRequest = (kind == 2'd2);
    cmdDone = (kind == 2'd0);
    @(negedge clk_sys);
    irqEvent = 1'b0;
    dataRequest = 1'b0;
    cmdDone = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  // A second command while busy must not start, so it leaves no note in the queue.
  task automatic runCmd(input logic [7:0] c, input logic twice);
    logic [7:0] sc, sn, ft, cl, ch, h;
    logic xf;
    atcr_exp_s e;
    sc = rnd();
    sn = rnd();
    ft = rnd();
    cl = rnd();
    ch = rnd();
    h = rnd();
    xf = c inside {8'h40, 8'h41, 8'h42};
    hw(1'b0, 3'h1, ft);
    hw(1'b0, 3'h2, sc);
    hw(1'b0, 3'h3, sn);
    hw(1'b0, 3'h4, cl);
    hw(1'b0, 3'h5, ch);
    hw(1'b0, 3'h6, {3'h5, twice, h[3:0]});
    e.code = c;
    e.kind = kindOf(c);
    e.sc = xf ? {lastSc, sc} : 16'h0000;
    e.sn = xf ? sn : 8'h00;
    e.drv = twice;
    lastSc = sc;
    e.cy = xf ? {ch, cl} : 16'h0000;
    e.hd = xf ? h[3:0] : 4'h0;
    e.ft = (c == 8'hef) ? ft : 8'h00;
    expQ.push_back(e);
    hw(1'b0, 3'h7, c);
    check(busyFlag === 1'b1 && expQ.size() == 0, "busy after start");
    if (twice) hw(1'b0, 3'h7, 8'h42);
    check(busyFlag === 1'b1, "busy before done");
    pulse({twice, 1'b0});
    check(busyFlag === 1'b0, "busy after done");
  endtask

  always @(negedge clk_sys) begin
    if (cmdStart === 1'b1) begin
      if (expQ.size() == 0) begin
        check(1'b0, "command started unasked");
      end else begin
        got = expQ.pop_front();
        check(cmdCode === got.code && cmdKind === got.kind, "code or kind");
        check(sectorCountParam === got.sc, "sector count");
        check(sectorNumberParam[7:0] === got.sn, "sector number");
        check(cylinderParam[15:0] === got.cy, "cylinder");
        check(driveSelectParam === got.drv, "drive select");
        check(headSelectParam === got.hd, "head select");
        check(featuresParam[7:0] === got.ft, "features");
      end
    end
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    $display("watchdog expired");
    n_mismatch++;
    wrap_up();
  end

  initial begin
    soft_reset_bit = 1'b1;
    {driveId, deviceFault, seekComplete, dataRequest, cmdDone, irqEvent} = 6'h00;
    driveReadyFlag = 1'b1;
    repeat (12) @(negedge clk_sys);
    soft_reset_bit = 1'b0;
    repeat (8) @(negedge clk_sys);
    d = rnd();
    deviceFault = d[0];
    seekComplete = d[1];
    repeat (4) @(negedge clk_sys);
    i_atcr_host_model.rd(1'b0, 3'h7, d);
    check(d === {2'b01, deviceFault, seekComplete, 4'h0}, "status");
    i_atcr_host_model.rd(1'b1, 3'h6, d);
    check(d === {2'b01, deviceFault, seekComplete, 4'h0}, "alternate status");
    $display("test status done");
    foreach (codes[i]) runCmd(codes[i], i == 2);
    $display("test command table done");
    hw(1'b0, 3'h7, 8'h01);
    check(abortErr === 1'b1 && busyFlag === 1'b0 && intrqOut === 1'b1, "abort");
    i_atcr_host_model.rd(1'b1, 3'h6, d);
    check(d[0] === 1'b1 && intrqOut === 1'b1, "alt read kept irq");
    i_atcr_host_model.rd(1'b0, 3'h7, d);
    check(d[0] === 1'b1 && intrqOut === 1'b0, "status read acked irq");
    pulse(2'd1);
    check(intrqOut === 1'b1, "irq raised");
    runCmd(8'h41, 1'b0);
    check(intrqOut === 1'b0 && abortErr === 1'b0, "command write dropped irq");
    driveReadyFlag = 1'b0;
    hw(1'b0, 3'h7, 8'h40);
    check(busyFlag === 1'b0, "not ready refused");
    driveReadyFlag = 1'b1;
    $display("test abort and interrupt done");
    hw(1'b1, 3'h6, 8'h02);
    check(intrqOe === 1'b0, "irq pin off");
    hw(1'b1, 3'h6, 8'h00);
    check(intrqOe === 1'b1, "irq pin on");
    hw(1'b0, 3'h6, 8'hb0);
    check(intrqOe === 1'b0, "other drive selected");
    hw(1'b1, 3'h6, 8'h80);
    check(highOrderByteSelect === 1'b1, "hob set");
    hw(1'b0, 3'h7, 8'h01);
    check(highOrderByteSelect === 1'b0, "hob cleared");
    hw(1'b1, 3'h6, 8'h04);
    check(busyFlag === 1'b1 && softResetOut === 1'b1, "soft reset held");
    hw(1'b1, 3'h6, 8'h00);
    check(busyFlag === 1'b0 && intrqOe === 1'b1 && abortErr === 1'b0, "after soft reset");
    $display("test device control done");
    wrap_up();
  end
endmodule
